/* File: core/dtf_pkg.sv */
// package of offsets, fields and reset values for the threshold/filter bank
// Notes on behaviour
// - 16-bit read/write upper threshold register at index 7h, resets to zero.
// - lower eight threshold bits sit in bits 15:8 of index 8h, reset zero.
// - index 8h resets 0000h; bits 7:4 read zero; host writes zeros there.
// - filter setting in bits 3:0 of index 8h, read/write, resets to zero.
// - setting zero bypasses the offset removal filter; data passes unfiltered.
// - nonzero code n gives coefficient 2 to the power -(n+1).
// - channel zero configuration register at index 9h, resets to zero.
// - current detection runs only while its enable bit is set; resets off.
package dtf_pkg;
  localparam logic [3:0] IDX_THR_HIGH = 4'h7;
  localparam logic [3:0] IDX_THR_LOW = 4'h8;
  localparam logic [3:0] IDX_CHANNEL0_CONFIG = 4'h9;
  localparam logic [3:0] IDX_GLOBAL_CFG = 4'h6;
  localparam logic [7:0] ADDR_THR_HIGH = {2'b00, IDX_THR_HIGH, 2'b00};
  localparam logic [7:0] ADDR_THR_LOW = {2'b00, IDX_THR_LOW, 2'b00};
  localparam logic [7:0] ADDR_CHANNEL0_CONFIG = {2'b00, IDX_CHANNEL0_CONFIG, 2'b00};
  localparam logic [7:0] ADDR_GLOBAL_CFG = {2'b00, IDX_GLOBAL_CFG, 2'b00};
  localparam logic [15:0] RST_THR_HIGH = 16'h0000;
  localparam logic [15:0] RST_THR_LOW = 16'h0000;
  localparam logic [15:0] RST_CHANNEL0_CONFIG = 16'h0000;
  localparam logic [15:0] RST_GLOBAL_CFG = 16'h0000;
  localparam int POS_THR_LOW_MSB = 15;
  localparam int POS_THR_LOW_LSB = 8;
  localparam int POS_COEF_MSB = 3;
  localparam int POS_COEF_LSB = 0;
  localparam int POS_CD_ON = 0;
  localparam logic [15:0] MASK_THR_LOW_WR = 16'hff0f;
  localparam int DATA_W = 24;
  localparam int ACC_W = 44;
endpackage : dtf_pkg

/* File: core/dtf_dc_filter.sv */
// offset removal filter, first order, shift coefficient
`timescale 1ns/1ps
`default_nettype none
module dtf_dc_filter
  import dtf_pkg::*;
#(
  parameter int W = DATA_W,
  parameter int AW = ACC_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [3:0] coef_sel,
  input wire logic in_valid,
  input wire logic signed [W-1:0] in_data,
  output logic out_valid,
  output logic signed [W-1:0] out_data
);
  // y = x - avg ; avg += (x - avg) * 2^-(n+1)
  logic signed [AW-1:0] avg;
  logic signed [AW-1:0] diff;
  logic signed [AW-1:0] x_ext;
  logic [4:0] shamt;

  function automatic logic [4:0] coef_shift(input logic [3:0] code);
    coef_shift = {1'b0, code} + 5'h01;
  endfunction

  assign shamt = coef_shift(coef_sel);
  assign x_ext = {in_data, {(AW-W){1'b0}}};
  assign diff = x_ext - avg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      avg <= '0;
    end else if (in_valid && coef_sel != 4'h0) begin
      avg <= avg + (diff >>> shamt);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      out_valid <= in_valid;
      if (in_valid) begin
        if (coef_sel == 4'h0) begin
          out_data <= in_data;
        end else begin
          out_data <= diff[AW-1 -: W];
        end
      end
    end
  end

  a_bypass_pass: assert property (@(posedge hclk) disable iff (!hresetn)
    in_valid && coef_sel == 4'h0 |=> out_valid && out_data == $past(in_data))
    else $error("bypass did not pass data");
endmodule : dtf_dc_filter
`default_nettype wire

/* File: core/dtf_detect.sv */
// current detect comparator against the 24-bit threshold
`timescale 1ns/1ps
`default_nettype none
module dtf_detect
  import dtf_pkg::*;
#(
  parameter int W = DATA_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic enable,
  input wire logic [W-1:0] threshold,
  input wire logic in_valid,
  input wire logic signed [W-1:0] in_data,
  output logic over
);
  logic [W-1:0] mag;
  assign mag = in_data[W-1] ? W'(-in_data) : in_data;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      over <= 1'b0;
    end else if (!enable) begin
      over <= 1'b0;
    end else if (in_valid) begin
      over <= mag > threshold;
    end
  end

  a_detect_off: assert property (@(posedge hclk) disable iff (!hresetn)
    !enable |=> !over)
    else $error("detect active while disabled");
endmodule : dtf_detect
`default_nettype wire

/* File: core/dtf_regs.sv */
// ahb-lite register bank for threshold, filter and channel zero config
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dtf_regs
  import dtf_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sample_valid,
  input wire logic [DATA_W-1:0] sample_data,
  output logic filt_valid,
  output logic [DATA_W-1:0] filt_data,
  output logic detect_over,
  output logic [15:0] channel0_config_out
);
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [15:0] detect_threshold_high;
  logic [7:0] threshold_lower_bits;
  logic [3:0] offset_removal_coeff_sel;
  logic [15:0] channel0_config;
  logic [15:0] global_cfg;
  logic current_detect_on;
  logic [23:0] threshold;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic rd_ok;
  logic f_valid;
  logic [DATA_W-1:0] f_data;
  logic over_i;
  logic [DATA_W-1:0] samp_q;
  logic samp_v;
  logic [15:0] next_detect_threshold_high;
  logic [7:0] next_threshold_lower_bits;
  logic [3:0] next_offset_removal_coeff_sel;
  logic [15:0] next_channel0_config;
  logic [15:0] next_global_cfg;

  function automatic logic [31:0] read_mux(input logic [7:0] a,
      input logic [15:0] hi, input logic [15:0] lo, input logic [15:0] c0,
      input logic [15:0] g);
    unique case (a)
      ADDR_THR_HIGH: read_mux = {16'h0000, hi};
      ADDR_THR_LOW: read_mux = {16'h0000, lo};
      ADDR_CHANNEL0_CONFIG: read_mux = {16'h0000, c0};
      ADDR_GLOBAL_CFG: read_mux = {16'h0000, g};
      default: read_mux = 32'h0000_0000;
    endcase
  endfunction

  assign current_detect_on = global_cfg[POS_CD_ON];
  assign threshold = {detect_threshold_high, threshold_lower_bits};
  assign rd_ok = hsel && hready && htrans[1] && !hwrite;

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= hsel && hready && htrans[1] && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (rd_ok) begin
        hrdata <= read_mux(haddr[7:0], next_detect_threshold_high,
          {next_threshold_lower_bits, 4'h0,
          next_offset_removal_coeff_sel},
          next_channel0_config, next_global_cfg);
      end
    end
  end

  // pending write, also read so a read right behind it sees new data
  always_comb begin
    next_detect_threshold_high = detect_threshold_high;
    next_threshold_lower_bits = threshold_lower_bits;
    next_offset_removal_coeff_sel = offset_removal_coeff_sel;
    next_channel0_config = channel0_config;
    next_global_cfg = global_cfg;
    if (wr_pend) begin
      unique case (wr_addr)
        ADDR_THR_HIGH: next_detect_threshold_high = hwdata[15:0];
        ADDR_THR_LOW: begin
          next_threshold_lower_bits = hwdata[POS_THR_LOW_MSB:POS_THR_LOW_LSB];
          next_offset_removal_coeff_sel = hwdata[POS_COEF_MSB:POS_COEF_LSB];
        end
        ADDR_CHANNEL0_CONFIG: next_channel0_config = hwdata[15:0];
        ADDR_GLOBAL_CFG: next_global_cfg = hwdata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      detect_threshold_high <= RST_THR_HIGH;
      threshold_lower_bits <= RST_THR_LOW[15:8];
      offset_removal_coeff_sel <= RST_THR_LOW[3:0];
      channel0_config <= RST_CHANNEL0_CONFIG;
      global_cfg <= RST_GLOBAL_CFG;
    end else begin
      detect_threshold_high <= next_detect_threshold_high;
      threshold_lower_bits <= next_threshold_lower_bits;
      offset_removal_coeff_sel <= next_offset_removal_coeff_sel;
      channel0_config <= next_channel0_config;
      global_cfg <= next_global_cfg;
    end
  end

  // ------------------------------------------------------------
  // datapath
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      samp_v <= 1'b0;
      samp_q <= '0;
    end else begin
      samp_v <= sample_valid;
      samp_q <= sample_data;
    end
  end

  dtf_dc_filter u_filter (
    .hclk(hclk),
    .hresetn(hresetn),
    .coef_sel(offset_removal_coeff_sel),
    .in_valid(samp_v),
    .in_data(samp_q),
    .out_valid(f_valid),
    .out_data(f_data)
  );

  dtf_detect u_detect (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(current_detect_on),
    .threshold(threshold),
    .in_valid(f_valid),
    .in_data(f_data),
    .over(over_i)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filt_valid <= 1'b0;
      filt_data <= '0;
      detect_over <= 1'b0;
      channel0_config_out <= 16'h0000;
    end else begin
      filt_valid <= f_valid;
      filt_data <= f_data;
      detect_over <= over_i;
      channel0_config_out <= channel0_config;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_low_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_ok && haddr[7:0] == ADDR_THR_LOW |=> hrdata[7:4] == 4'h0)
    else $error("reserved bits not zero");
  a_high_write_lands: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend && wr_addr == ADDR_THR_HIGH |=>
    detect_threshold_high == $past(hwdata[15:0]))
    else $error("upper threshold write lost");
  a_low_write_lands: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend && wr_addr == ADDR_THR_LOW |=>
    threshold_lower_bits == $past(hwdata[15:8]) &&
    offset_removal_coeff_sel == $past(hwdata[3:0]))
    else $error("lower threshold write lost");
  a_ch0_write_lands: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend && wr_addr == ADDR_CHANNEL0_CONFIG |=>
    channel0_config == $past(hwdata[15:0]))
    else $error("channel zero write lost");
  a_thresh_join: assert property (@(posedge hclk) disable iff (!hresetn)
    f_valid && current_detect_on && !f_data[DATA_W-1] &&
    f_data > {detect_threshold_high, threshold_lower_bits}
    |=> over_i)
    else $error("threshold join wrong");
  a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("slave not okay");
  a_detect_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    !current_detect_on ##1 !current_detect_on |=> !detect_over)
    else $error("detect output while off");
  a_coef_read: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_ok && haddr[7:0] == ADDR_THR_LOW |=>
    hrdata[3:0] == offset_removal_coeff_sel)
    else $error("filter setting read wrong");

  c_write_low: cover property (@(posedge hclk) wr_pend && wr_addr == ADDR_THR_LOW);
  c_filter_on: cover property (@(posedge hclk)
    f_valid && offset_removal_coeff_sel != 4'h0);
  c_detect_hit: cover property (@(posedge hclk) detect_over);
  c_write_then_read: cover property (@(posedge hclk) wr_pend && rd_ok);

  a_high_read: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_ok && haddr[7:0] == ADDR_THR_HIGH |=>
    hrdata == {16'h0000, detect_threshold_high})
    else $error("upper threshold read wrong");
  a_ch0_copy: assert property (@(posedge hclk) disable iff (!hresetn)
    channel0_config_out == $past(channel0_config))
    else $error("channel zero copy wrong");
  a_enable_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend && wr_addr == ADDR_GLOBAL_CFG |=>
    current_detect_on == $past(hwdata[POS_CD_ON]))
    else $error("detect enable write lost");
endmodule : dtf_regs
`default_nettype wire

/* File: tb/dtf_testbench.sv */
// self-checking bench for the threshold and filter register bank
`timescale 1ns/1ps
`default_nettype none
module testbench
  import dtf_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, sample_valid;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, filt_valid, detect_over, det;
  logic [DATA_W-1:0] sample_data, filt_data, y;
  logic [15:0] channel0_config_out;
  int err_total, cmp_count;
  // address, write data, read-back value
  logic [31:0] rows [0:4][0:2] = '{
    '{32'h1c, 32'hffffffff, 32'h0000ffff},
    '{32'h20, 32'hffffff0f, 32'h0000ff0f},
    '{32'h24, 32'h0000a5c3, 32'h0000a5c3},
    '{32'h18, 32'h0000fffe, 32'h0000fffe},
    '{32'h3c, 32'h00001234, 32'h00000000}};
  // filter code, expected second output for a step of 40000h
  logic [31:0] ftab [0:3][0:1] = '{
    '{32'h0, 32'h040000}, '{32'h1, 32'h030000},
    '{32'h7, 32'h03fc00}, '{32'hf, 32'h03fffc}};

  dtf_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sample_valid(sample_valid), .sample_data(sample_data),
    .filt_valid(filt_valid), .filt_data(filt_data),
    .detect_over(detect_over), .channel0_config_out(channel0_config_out));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic hang(input int n);
    if (n > 20) begin
      err_total++;
      $display("unexpected at %0t: wait ran out", $time);
      final_report;
    end
  endtask

  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      hang(n);
      @(posedge hclk);
    end
  endtask

  task automatic ahb(input logic [31:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    wait_rdy;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy;
    r = hrdata;
  endtask

  task automatic reset_dut;
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask

  task automatic send(input logic [DATA_W-1:0] x,
                      output logic [DATA_W-1:0] yo, output logic d);
    int n;
    n = 0;
    sample_valid <= 1'b1;
    sample_data <= x;
    @(posedge hclk);
    sample_valid <= 1'b0;
    @(posedge hclk);
    do begin
      @(posedge hclk);
      #1;
      n++;
      hang(n);
    end while (filt_valid !== 1'b1);
    chk(n, 1);
    yo = filt_data;
    @(posedge hclk);
    #1;
    d = detect_over;
    @(posedge hclk);
  endtask

  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  initial begin
    repeat (20000) @(posedge hclk);
    err_total++;
    $display("unexpected at %0t: run too long", $time);
    final_report;
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = '0;
    sample_valid = 1'b0;
    sample_data = '0;
    err_total = 0;
    cmp_count = 0;
    reset_dut;
    chk(channel0_config_out, 32'h0);
    chk(hresp, 32'h0);
    for (int i = 0; i < 5; i++) begin
      ahb(rows[i][0], 1'b0, 32'h0, rd);
      chk(rd, 32'h0);
      ahb(rows[i][0], 1'b1, rows[i][1], rd);
      ahb(rows[i][0], 1'b0, 32'h0, rd);
      chk(rd, rows[i][2]);
    end
    chk(channel0_config_out, 32'ha5c3);
    $display("register table test done");
    for (int i = 0; i < 4; i++) begin
      reset_dut;
      ahb(32'h20, 1'b1, ftab[i][0], rd);
      send(24'h040000, y, det);
      send(24'h040000, y, det);
      chk(y, ftab[i][1]);
    end
    chk(channel0_config_out, 32'h0);
    ahb(32'h24, 1'b0, 32'h0, rd);
    chk(rd, 32'h0);
    $display("filter test done");
    ahb(32'h20, 1'b1, 32'h00000100, rd);
    ahb(32'h1c, 1'b1, 32'h00000004, rd);
    send(24'h000402, y, det);
    chk(det, 32'h0);
    ahb(32'h18, 1'b1, 32'h00000001, rd);
    send(24'h000402, y, det);
    chk(det, 32'h1);
    send(24'h000401, y, det);
    chk(det, 32'h0);
    ahb(32'h18, 1'b1, 32'h00000000, rd);
    send(24'h000402, y, det);
    chk(det, 32'h0);
    $display("detect test done");
    final_report;
  end
endmodule // testbench
`default_nettype wire
